// File: host_port_irq_defines.svh
`ifndef HOST_PORT_IRQ_DEFINES_SVH
`define HOST_PORT_IRQ_DEFINES_SVH
// -----------------------------------------------------------------
// register offsets on the host port and the cpu side
// -----------------------------------------------------------------
`define OFS_BREAKPOINT   16'h0140
`define OFS_DEST_SELECT  16'h0142
`define OFS_ENG1_MSG     16'h0144
`define OFS_ENG2_MSG     16'h0148
`define OFS_MAILBOX      16'hC0C6
// -----------------------------------------------------------------
// destination select fields and reset value
// -----------------------------------------------------------------
`define DEST_RESET       16'h1400
`define BIT_VBUS         15
`define BIT_ID           14
`define BIT_SOF2_HOST    13
`define BIT_SOF2_CPU     12
`define BIT_SOF1_HOST    11
`define BIT_SOF1_CPU     10
`define BIT_RESET2       9
`define BIT_SWAP_HIGH    8
`define BIT_RESUME2      7
`define BIT_RESUME1      6
`define BIT_DONE2        3
`define BIT_DONE1        2
`define BIT_RESET1       1
`define BIT_SWAP_LOW     0
// sources diverted whole to the host when their bit is one
`define DIVERT_MASK      16'hC2CE
// -----------------------------------------------------------------
// status word layout seen by the host
// -----------------------------------------------------------------
`define ST_SOF2          12
`define ST_SOF1          10
`define ST_MBOX_IN       8
`define ST_MSG2          5
`define ST_MSG1          4
`define ST_MBOX_OUT      0
// source positions valid on the engine interrupt input
`define SOURCE_MASK      16'hD6CE
`endif

// File: host_port_irq_pkg.sv
package host_port_irq_pkg;
  // one host-port or cpu data word
  typedef logic [15:0] word_t;
endpackage

// File: host_port_interrupt_routing.sv
`timescale 1ns/10ps
`include "host_port_irq_defines.svh"
// Function
// - routed engine interrupt drives pin and status
// - destination register writable by host only
// - routing picks destination, enables live upstream
// - bit 15 diverts vbus interrupt to host
// - bit 14 diverts id interrupt to host
// - bits 13/11 send frame interrupts to host
// - bits 12/10 send frame interrupts to cpu
// - bits 9/1 divert bus-reset interrupts to host
// - bits 7/6 divert resume interrupts to host
// - bits 3/2 divert done interrupts to host
// - both swap bits set swaps host bytes
// - swap bits clear keep bytes in place
// - host-visible 16-bit breakpoint at 0x0140
// - program counter match raises breakpoint interrupt
// - five registers at their fixed offsets
// - host reads a status word directly
// - message write sets flag, host read clears
module host_port_interrupt_routing
  import host_port_irq_pkg::*;
#(
  parameter int WIDTH = 16                // host and cpu data width
) (
  input  wire logic  clock,
  input  wire logic  reset_n,
  // host port access
  input  wire logic  hostRead,            // one-cycle read strobe
  input  wire logic  hostWrite,           // one-cycle write strobe
  input  wire logic  hostStatusRead,      // status word read strobe
  input  wire word_t hostAddr,
  input  wire word_t hostDataIn,          // as seen on the data lines
  output word_t      hostDataOut,         // as put on the data lines
  output logic       hostPortIrqPin,      // high while host attention needed
  // cpu access
  input  wire logic  cpuRead,
  input  wire logic  cpuWrite,
  input  wire word_t cpuAddr,
  input  wire word_t cpuDataIn,
  output word_t      cpuDataOut,
  // interrupt sources and cpu side outputs
  input  wire word_t engineIrq,           // enabled source levels
  input  wire word_t programCounter,
  output word_t      cpuIrq,              // sources delivered to the cpu
  output logic       breakpointIrq,
  output logic       mailboxRxIrq,        // host filled the mailbox
  output logic       mailboxTxIrq         // host emptied the mailbox
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  word_t breakAddr;                       // host breakpoint address
  word_t destSelect;                      // interrupt destination select
  word_t mailbox;                         // shared message word
  logic  msg1Flag;                        // engine 1 message pending
  logic  msg2Flag;                        // engine 2 message pending
  logic  mboxOutFlag;                     // cpu wrote mailbox for host
  word_t hostRoute;                       // per status bit host route
  word_t statusWord;                      // live status for the host
  word_t hostDataIn_sw;                   // write data in byte order
  logic  swapOn;                          // both swap bits set
  logic  hostWrBreak;
  logic  hostWrDest;
  logic  hostWrMbox;
  logic  hostRdMbox;
  logic  hostRdMsg1;
  logic  hostRdMsg2;
  logic  cpuWrMbox;
  logic  cpuRdMbox;
  logic  cpuWrMsg1;
  logic  cpuWrMsg2;
  word_t next_hostData;
  word_t next_cpuData;
  word_t next_cpuIrq;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  // fixed offsets, unmapped offsets read as zero
  assign hostWrBreak = hostWrite && (hostAddr == `OFS_BREAKPOINT);
  assign hostWrDest  = hostWrite && (hostAddr == `OFS_DEST_SELECT);
  assign hostWrMbox  = hostWrite && (hostAddr == `OFS_MAILBOX);
  assign hostRdMbox  = hostRead && (hostAddr == `OFS_MAILBOX);
  assign hostRdMsg1  = hostRead && (hostAddr == `OFS_ENG1_MSG);
  assign hostRdMsg2  = hostRead && (hostAddr == `OFS_ENG2_MSG);
  assign cpuWrMbox   = cpuWrite && (cpuAddr == `OFS_MAILBOX);
  assign cpuRdMbox   = cpuRead && (cpuAddr == `OFS_MAILBOX);
  assign cpuWrMsg1   = cpuWrite && (cpuAddr == `OFS_ENG1_MSG);
  assign cpuWrMsg2   = cpuWrite && (cpuAddr == `OFS_ENG2_MSG);

  // -----------------------------------------------------------------
  // byte lane order on the host data lines
  // -----------------------------------------------------------------
  // a mismatched pair is treated as no swap; software must keep them equal
  assign swapOn = destSelect[`BIT_SWAP_HIGH] & destSelect[`BIT_SWAP_LOW];
  assign hostDataIn_sw = swapOn ? {hostDataIn[7:0], hostDataIn[15:8]}
                                : hostDataIn;

  // -----------------------------------------------------------------
  // breakpoint register
  // -----------------------------------------------------------------
  // only the host writes it, the cpu reads it back
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      breakAddr <= 16'h0000;
    end else if (hostWrBreak) begin
      breakAddr <= hostDataIn_sw;
    end
  end

  // sticky match; a zero address is the parked, cleared state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      breakpointIrq <= 1'b0;
    end else if (breakAddr != 16'h0000 && programCounter == breakAddr) begin
      breakpointIrq <= 1'b1;
    end else if (hostWrBreak && hostDataIn_sw == 16'h0000) begin
      breakpointIrq <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // destination select register
  // -----------------------------------------------------------------
  // cpu writes to this offset are dropped on purpose
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      destSelect <= `DEST_RESET;
    end else if (hostWrDest) begin
      destSelect <= hostDataIn_sw;
    end
  end

  // -----------------------------------------------------------------
  // message flags
  // -----------------------------------------------------------------
  // a new cpu write beats a host read in the same cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      msg1Flag <= 1'b0;
    end else if (cpuWrMsg1) begin
      msg1Flag <= 1'b1;
    end else if (hostRdMsg1) begin
      msg1Flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      msg2Flag <= 1'b0;
    end else if (cpuWrMsg2) begin
      msg2Flag <= 1'b1;
    end else if (hostRdMsg2) begin
      msg2Flag <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // mailbox
  // -----------------------------------------------------------------
  // host write wins a same-cycle collision on the data word
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mailbox <= 16'h0000;
    end else if (hostWrMbox) begin
      mailbox <= hostDataIn_sw;
    end else if (cpuWrMbox) begin
      mailbox <= cpuDataIn;
    end
  end

  // cpu write raises the host pin, host read drops it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mboxOutFlag <= 1'b0;
    end else if (cpuWrMbox) begin
      mboxOutFlag <= 1'b1;
    end else if (hostRdMbox) begin
      mboxOutFlag <= 1'b0;
    end
  end

  // receive full toward the cpu
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mailboxRxIrq <= 1'b0;
    end else if (hostWrMbox) begin
      mailboxRxIrq <= 1'b1;
    end else if (cpuRdMbox) begin
      mailboxRxIrq <= 1'b0;
    end
  end

  // transmit empty toward the cpu
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mailboxTxIrq <= 1'b0;
    end else if (hostRdMbox) begin
      mailboxTxIrq <= 1'b1;
    end else if (cpuWrMbox) begin
      mailboxTxIrq <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // routing
  // -----------------------------------------------------------------
  // frame interrupts sit one bit below their host select in the status
  always_comb begin
    hostRoute = destSelect & `DIVERT_MASK;
    hostRoute[`ST_SOF2] = destSelect[`BIT_SOF2_HOST];
    hostRoute[`ST_SOF1] = destSelect[`BIT_SOF1_HOST];
  end

  // upstream enables already gate engineIrq; routing never enables
  always_comb begin
    statusWord = engineIrq & `SOURCE_MASK & hostRoute;
    statusWord[`ST_MBOX_IN]  = mailboxRxIrq;
    statusWord[`ST_MSG2]     = msg2Flag;
    statusWord[`ST_MSG1]     = msg1Flag;
    statusWord[`ST_MBOX_OUT] = mboxOutFlag;
  end

  // diverted sources leave the cpu; frame sources follow their own bits
  always_comb begin
    next_cpuIrq = engineIrq & `DIVERT_MASK & ~destSelect;
    next_cpuIrq[`ST_SOF2] = engineIrq[`ST_SOF2] & destSelect[`BIT_SOF2_CPU];
    next_cpuIrq[`ST_SOF1] = engineIrq[`ST_SOF1] & destSelect[`BIT_SOF1_CPU];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpuIrq <= 16'h0000;
    end else begin
      cpuIrq <= next_cpuIrq;
    end
  end

  // every bit of the status word asks for host attention
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hostPortIrqPin <= 1'b0;
    end else begin
      hostPortIrqPin <= |statusWord[15:1] | mboxOutFlag;
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  // status reads bypass the register map and cost no memory cycle
  always_comb begin
    next_hostData = 16'h0000;
    if (hostStatusRead) begin
      next_hostData = statusWord;
    end else if (hostRead) begin
      unique case (hostAddr)
        `OFS_BREAKPOINT:  next_hostData = breakAddr;
        `OFS_DEST_SELECT: next_hostData = destSelect;
        `OFS_MAILBOX:     next_hostData = mailbox;
        default:          next_hostData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hostDataOut <= 16'h0000;
    end else if (swapOn) begin
      hostDataOut <= {next_hostData[7:0], next_hostData[15:8]};
    end else begin
      hostDataOut <= next_hostData;
    end
  end

  // the cpu sees the same words but never the status port
  always_comb begin
    next_cpuData = 16'h0000;
    if (cpuRead) begin
      unique case (cpuAddr)
        `OFS_BREAKPOINT:  next_cpuData = breakAddr;
        `OFS_DEST_SELECT: next_cpuData = destSelect;
        `OFS_MAILBOX:     next_cpuData = mailbox;
        default:          next_cpuData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpuDataOut <= 16'h0000;
    end else begin
      cpuDataOut <= next_cpuData;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_cpu_write_ignored: assert property (
    cpuWrite && cpuAddr == `OFS_DEST_SELECT && !hostWrDest |=> $stable(destSelect))
    else $error("cpu write changed destination select");

  a_vbus_to_host: assert property (
    engineIrq[`BIT_VBUS] && destSelect[`BIT_VBUS] |=> hostPortIrqPin && !cpuIrq[`BIT_VBUS])
    else $error("vbus interrupt not diverted to host");

  a_id_to_cpu: assert property (
    engineIrq[`BIT_ID] && !destSelect[`BIT_ID] |=> cpuIrq[`BIT_ID])
    else $error("id interrupt lost for cpu");

  a_frame_both: assert property (
    engineIrq[`ST_SOF2] && destSelect[`BIT_SOF2_CPU] && destSelect[`BIT_SOF2_HOST]
    |=> cpuIrq[`ST_SOF2] && hostPortIrqPin)
    else $error("frame interrupt not sent to both");

  a_frame_cpu_off: assert property (
    !destSelect[`BIT_SOF1_CPU] |=> !cpuIrq[`ST_SOF1])
    else $error("frame interrupt reached cpu while off");

  a_swap_read: assert property (
    hostRead && !hostStatusRead && hostAddr == `OFS_DEST_SELECT && swapOn
    |=> hostDataOut == {$past(destSelect[7:0]), $past(destSelect[15:8])})
    else $error("swapped read lanes wrong");

  a_break_match: assert property (
    breakAddr != 16'h0000 && programCounter == breakAddr |=> breakpointIrq)
    else $error("breakpoint match not raised");

  a_break_hold: assert property (
    breakpointIrq && !hostWrBreak |=> breakpointIrq)
    else $error("breakpoint dropped without clear");

  a_msg_set_pin: assert property (
    cpuWrMsg1 |=> msg1Flag ##1 hostPortIrqPin)
    else $error("message write did not reach pin");

  a_msg_read_clear: assert property (
    hostRdMsg2 && !cpuWrMsg2 |=> !msg2Flag)
    else $error("message flag not cleared by host read");

  a_quiet_pin: assert property (
    statusWord == 16'h0000 && !mboxOutFlag |=> !hostPortIrqPin)
    else $error("host pin high with nothing pending");

  c_route_done: cover property (engineIrq[`BIT_DONE1] && destSelect[`BIT_DONE1] ##1 hostPortIrqPin);
  c_break_hit:  cover property (!breakpointIrq ##1 breakpointIrq);
  c_mbox_trip:  cover property (cpuWrMbox ##[1:20] hostRdMbox);
  c_swap_set:   cover property (hostWrDest ##1 swapOn);

endmodule

// File: host_proc_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// external host processor on the host port
// ---------------------------------------------------------------
module host_proc_model
  import host_port_irq_pkg::*;
(
  input  wire logic clock,
  output logic      hostRead,
  output logic      hostWrite,
  output logic      hostStatusRead,
  output word_t     hostAddr,
  output word_t     hostDataIn
);
  word_t expQ[$];                        // expected read data, oldest first

  // idle port at time zero
  initial begin
    hostRead       = 1'b0;
    hostWrite      = 1'b0;
    hostStatusRead = 1'b0;
    hostAddr       = 16'h0000;
    hostDataIn     = 16'h0000;
  end

  // one write; callers keep both swap bits equal
  task automatic hwrite(input word_t addr, input word_t data);
    @(posedge clock);
    hostWrite  <= 1'b1;
    hostAddr   <= addr;
    hostDataIn <= data;
    @(posedge clock);
    hostWrite  <= 1'b0;
    // released lines must not look like a held word
    hostDataIn <= ~data;
  endtask

  // register or status read; the answer is noted for the monitor
  task automatic hread(input logic st, input word_t addr, input word_t exp);
    @(posedge clock);
    hostRead       <= ~st;
    hostStatusRead <= st;
    hostAddr       <= addr;
    expQ.push_back(exp);
    @(posedge clock);
    hostRead       <= 1'b0;
    hostStatusRead <= 1'b0;
  endtask
endmodule

// File: host_port_interrupt_routing_tb.sv
`timescale 1ns/10ps
`include "host_port_irq_defines.svh"
module host_port_interrupt_routing_tb
  import host_port_irq_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clock;
  logic        reset_n;
  logic        hostRead;
  logic        hostWrite;
  logic        hostStatusRead;
  word_t       hostAddr;
  word_t       hostDataIn;
  word_t       hostDataOut;
  logic        hostPortIrqPin;
  logic        cpuRead;
  logic        cpuWrite;
  word_t       cpuAddr;
  word_t       cpuDataIn;
  word_t       cpuDataOut;
  word_t       engineIrq;
  word_t       programCounter;
  word_t       cpuIrq;
  logic        breakpointIrq;
  logic        mailboxRxIrq;
  logic        mailboxTxIrq;
  logic        probeReq  = 1'b0;       // asks the monitor to look at the flags
  logic        hostSeen  = 1'b0;       // strobes sampled at the last edge
  logic        cpuSeen   = 1'b0;
  logic        probeSeen = 1'b0;
  word_t       cpuQ[$];                // expected cpu read data
  logic [19:0] probeQ[$];              // {pin, break, rx, tx, cpuIrq}
  int          fails = 0;
  int          samplesChecked = 0;
  word_t       dest;
  word_t       eng;
  word_t       cpuExp;
  word_t       hostExp;

  host_port_interrupt_routing i_host_port_interrupt_routing (
    .clock(clock), .reset_n(reset_n), .hostRead(hostRead), .hostWrite(hostWrite),
    .hostStatusRead(hostStatusRead), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostPortIrqPin(hostPortIrqPin), .cpuRead(cpuRead),
    .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuDataIn(cpuDataIn),
    .cpuDataOut(cpuDataOut), .engineIrq(engineIrq), .programCounter(programCounter),
    .cpuIrq(cpuIrq), .breakpointIrq(breakpointIrq), .mailboxRxIrq(mailboxRxIrq),
    .mailboxTxIrq(mailboxTxIrq));

  host_proc_model i_host_proc_model (
    .clock(clock), .hostRead(hostRead), .hostWrite(hostWrite),
    .hostStatusRead(hostStatusRead), .hostAddr(hostAddr), .hostDataIn(hostDataIn));

  // ---------------------------------------------------------------
  // clock, watchdog and checking helpers
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // the run needs well under 2000 cycles
  initial begin
    #100000;
    fails++;
    give_verdict();
  end

  task automatic compare(input logic [19:0] got, input logic [19:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // monitor: answers land one edge after the strobe edge
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    hostSeen  <= hostRead | hostStatusRead;
    cpuSeen   <= cpuRead;
    probeSeen <= probeReq;
  end

  // look mid-cycle so the registered outputs have settled
  always @(negedge clock) begin
    if (hostSeen === 1'b1)
      compare({4'h0, hostDataOut}, {4'h0, i_host_proc_model.expQ.pop_front()});
    if (cpuSeen === 1'b1)
      compare({4'h0, cpuDataOut}, {4'h0, cpuQ.pop_front()});
    if (probeSeen === 1'b1)
      compare({hostPortIrqPin, breakpointIrq, mailboxRxIrq, mailboxTxIrq, cpuIrq},
              probeQ.pop_front());
  end

  // ---------------------------------------------------------------
  // cpu side driver tasks
  // ---------------------------------------------------------------
  task automatic cpu_access(input logic wr, input word_t addr, input word_t data);
    @(posedge clock);
    cpuWrite  <= wr;
    cpuRead   <= ~wr;
    cpuAddr   <= addr;
    cpuDataIn <= data;
    if (!wr)
      cpuQ.push_back(data);
    @(posedge clock);
    cpuWrite <= 1'b0;
    cpuRead  <= 1'b0;
  endtask

  task automatic probe(input logic [19:0] exp);
    @(posedge clock);
    probeReq <= 1'b1;
    probeQ.push_back(exp);
    @(posedge clock);
    probeReq <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n        = 1'b0;
    cpuRead        = 1'b0;
    cpuWrite       = 1'b0;
    cpuAddr        = 16'h0000;
    cpuDataIn      = 16'h0000;
    engineIrq      = 16'h0000;
    programCounter = 16'h0000;
    void'($urandom(97));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    // reset values and the map
    i_host_proc_model.hread(1'b0, `OFS_DEST_SELECT, 16'h1400);
    i_host_proc_model.hread(1'b0, `OFS_BREAKPOINT, 16'h0000);
    i_host_proc_model.hread(1'b0, 16'h0150, 16'h0000);
    cpu_access(1'b1, `OFS_DEST_SELECT, 16'hFFFF);
    i_host_proc_model.hread(1'b0, `OFS_DEST_SELECT, 16'h1400);
    // routing: two corners, then random masks and sources
    for (int i = 0; i < 24; i++) begin
      dest = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFECE : 16'($urandom()) & 16'hFECE;
      eng  = (i < 2) ? 16'hFFFF : 16'($urandom());
      cpuExp      = eng & ~dest & `DIVERT_MASK;
      cpuExp[12]  = eng[12] & dest[12];
      cpuExp[10]  = eng[10] & dest[10];
      hostExp     = eng & dest & `DIVERT_MASK;
      hostExp[12] = eng[12] & dest[13];
      hostExp[10] = eng[10] & dest[11];
      i_host_proc_model.hwrite(`OFS_DEST_SELECT, dest);
      @(posedge clock);
      engineIrq <= eng;
      cpu_access(1'b0, `OFS_DEST_SELECT, dest);
      probe({|hostExp, 3'b000, cpuExp});
      i_host_proc_model.hread(1'b1, 16'h0000, hostExp);
    end
    @(posedge clock);
    engineIrq <= 16'h0000;
    i_host_proc_model.hwrite(`OFS_DEST_SELECT, 16'h1400);
    // message triggers raise the pin until the host reads them
    for (int m = 0; m < 2; m++) begin
      cpu_access(1'b1, m ? `OFS_ENG2_MSG : `OFS_ENG1_MSG, 16'h5A5A);
      probe(20'h80000);
      i_host_proc_model.hread(1'b1, 16'h0000, m ? 16'h0020 : 16'h0010);
      i_host_proc_model.hread(1'b0, m ? `OFS_ENG2_MSG : `OFS_ENG1_MSG, 16'h0000);
      probe(20'h00000);
    end
    // mailbox, first with bytes in place, then swapped
    i_host_proc_model.hwrite(`OFS_MAILBOX, 16'h1234);
    probe(20'hA0000);
    cpu_access(1'b0, `OFS_MAILBOX, 16'h1234);
    i_host_proc_model.hwrite(`OFS_DEST_SELECT, 16'h0101);
    i_host_proc_model.hread(1'b0, `OFS_DEST_SELECT, 16'h0101);
    i_host_proc_model.hwrite(`OFS_MAILBOX, 16'h1234);
    cpu_access(1'b0, `OFS_MAILBOX, 16'h3412);
    cpu_access(1'b1, `OFS_MAILBOX, 16'hABCD);
    probe(20'h80000);
    i_host_proc_model.hread(1'b0, `OFS_MAILBOX, 16'hCDAB);
    probe(20'h10000);
    i_host_proc_model.hwrite(`OFS_DEST_SELECT, 16'h0000);
    // breakpoint set, matched, refused from the cpu, cleared by zero
    i_host_proc_model.hwrite(`OFS_BREAKPOINT, 16'h0200);
    @(posedge clock);
    programCounter <= 16'h0200;
    probe(20'h50000);
    cpu_access(1'b1, `OFS_BREAKPOINT, 16'h1111);
    cpu_access(1'b0, `OFS_BREAKPOINT, 16'h0200);
    @(posedge clock);
    programCounter <= 16'h0300;
    i_host_proc_model.hwrite(`OFS_BREAKPOINT, 16'h0000);
    probe(20'h10000);
    repeat (4) @(posedge clock);
    give_verdict();
  end
endmodule
